// ### logic/bxh_pkg.sv
package branch_seq_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_INSTR  = 8'h04;
   localparam logic [7:0] REG_FIRST  = 8'h08;
   localparam logic [7:0] REG_BADDR  = 8'h0C;
   localparam logic [7:0] REG_ICNT   = 8'h10;
   localparam logic [7:0] REG_STAT   = 8'h14;
   localparam logic [7:0] REG_SUM    = 8'h18;
   localparam logic [7:0] REG_NEXTOP = 8'h1C;
   localparam logic [7:0] REG_QHI    = 8'h20;
   localparam logic [7:0] REG_QLO    = 8'h24;
   localparam logic [7:0] REG_GADDR  = 8'h28;
   localparam logic [7:0] REG_GDATA  = 8'h2C;

   // Control bit positions
   localparam int CTRL_START = 0;
   localparam int CTRL_EXEC  = 1;
   localparam int CTRL_PFI   = 2;

   // ****************************************
   // Instruction and addressing constants
   // ****************************************
   localparam logic [7:0]  OPC_BIX  = 8'h86;
   localparam logic [1:0]  HW_LAST  = 2'h3;
   localparam logic [1:0]  HW_FIRST = 2'h0;
   localparam logic [23:0] DW_STEP  = 24'h00_0008;
   localparam logic [1:0]  STORE_LAT = 2'h3;

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // Refill kinds after a storage request
   localparam logic [1:0] FM_TARGET    = 2'h0;
   localparam logic [1:0] FM_SEQ_LAST  = 2'h1;
   localparam logic [1:0] FM_SEQ_FIRST = 2'h2;

   typedef enum logic [7:0] {
      S_IDLE   = 8'b0000_0001,
      S_MOVE   = 8'b0000_0010,
      S_ADD    = 8'b0000_0100,
      S_CMP    = 8'b0000_1000,
      S_DECIDE = 8'b0001_0000,
      S_REQ    = 8'b0010_0000,
      S_WAIT   = 8'b0100_0000,
      S_FILL   = 8'b1000_0000
   } seq_state_t;

endpackage : branch_seq_pkg

// ### logic/par_adder.sv
`timescale 1ns/1ps

// ****************************************
// Parallel adder with algebraic sign result
// ****************************************
module par_adder (
   input  wire logic [31:0] a,
   input  wire logic [31:0] b,
   input  wire logic        sub,
   output      logic [31:0] sum,
   output      logic        positive
);

   // One guard bit keeps the compare exact across overflow
   logic [32:0] ext_a;
   logic [32:0] ext_b;
   logic [32:0] wide;

   assign ext_a    = {a[31], a};
   assign ext_b    = sub ? ~{b[31], b} : {b[31], b};
   assign wide     = ext_a + ext_b + {32'h0000_0000, sub};
   assign sum      = wide[31:0];
   assign positive = !wide[32] && (wide != 33'h0_0000_0000);

endmodule : par_adder

// ### logic/branch_index_high_seq.sv
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module branch_index_high_seq
   import branch_seq_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output      logic              storage_req,
   output      logic [23:0]       storage_addr,
   input  wire logic [63:0]       storage_out_bus,
   output      logic              end_op,
   output      logic              end_branch
);

   // ****************************************
   // State and datapath
   // ****************************************
   seq_state_t        state;
   seq_state_t        next_state;
   logic [31:0]       local_store [16];
   logic [15:0]       instr;
   logic [31:0]       first_op;
   logic [23:0]       baddr;
   logic [23:0]       instr_counter;
   logic [31:0]       sum_latch;
   logic [31:0]       work;
   logic              adder_result_latches;
   logic              seq_need;
   logic              success;
   logic [63:0]       prefetch;
   logic [15:0]       next_op;
   logic              prefetch_invalid_flag;
   logic              exec_flag;
   logic              done;
   logic              end_pulse;
   logic [1:0]        fill_mode;
   logic [1:0]        wait_cnt;
   logic [3:0]        gpr_addr;

   // ****************************************
   // Bus holding registers
   // ****************************************
   logic              aw_full;
   logic              w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;

   // ****************************************
   // Decode
   // ****************************************
   wire [3:0]  r1       = instr[7:4];
   wire [3:0]  r3       = instr[3:0];
   wire        e7       = instr[8];
   wire [1:0]  d_hw     = baddr[2:1];
   wire [1:0]  cnt_hw   = instr_counter[2:1];
   wire        idle     = (state == S_IDLE);
   wire [3:0]  cmp_reg  = r3 | 4'h1;
   wire [31:0] add_sum;
   wire        add_pos;
   wire [15:0] d_half;
   wire [15:0] q_first  = storage_out_bus[63:48];

   par_adder u_adder (
      .a        (sum_latch),
      .b        (work),
      .sub      (state == S_CMP),
      .sum      (add_sum),
      .positive (add_pos)
   );

   assign d_half = (d_hw == 2'h0) ? storage_out_bus[63:48] :
                   (d_hw == 2'h1) ? storage_out_bus[47:32] :
                   (d_hw == 2'h2) ? storage_out_bus[31:16] :
                                    storage_out_bus[15:0];

   wire        take     = adder_result_latches && !e7;
   wire        hw_edge  = (cnt_hw == HW_LAST) || (cnt_hw == HW_FIRST);

   // ****************************************
   // Bus decode
   // ****************************************
   wire        wr_go    = aw_full && w_full && !s_axi_bvalid;
   wire        ar_go    = s_axi_arvalid && s_axi_arready;
   wire [7:0]  wa       = aw_addr[7:0];
   wire [7:0]  ra       = s_axi_araddr[7:0];
   wire        wr_ok    = (wa <= REG_GDATA) && (wa[1:0] == 2'h0);
   wire        rd_ok    = (ra <= REG_GDATA) && (ra[1:0] == 2'h0);
   wire        wr_idle  = wr_go && wr_ok && idle;
   wire [31:0] wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}},
                           {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire        w_ctrl   = wr_idle && (wa == REG_CTRL);
   wire        start    = w_ctrl && w_strb[0] && w_data[CTRL_START] &&
                          (instr[15:8] == OPC_BIX);
   wire        set_exec = w_ctrl && w_strb[0] && w_data[CTRL_EXEC];
   wire        set_pfi  = w_ctrl && w_strb[0] && w_data[CTRL_PFI];
   wire        clr_flag = (state == S_DECIDE) && take;
   wire        w_gdata  = wr_idle && (wa == REG_GDATA);
   wire        gpr_wb   = (state == S_DECIDE);

   wire [31:0] status   = {24'h00_0000, 1'b0, done, end_branch, success,
                           exec_flag, prefetch_invalid_flag, 1'b0, !idle};
   wire [31:0] rd_mux   =
      (ra == REG_INSTR)  ? {16'h0000, instr} :
      (ra == REG_FIRST)  ? first_op :
      (ra == REG_BADDR)  ? {8'h00, baddr} :
      (ra == REG_ICNT)   ? {8'h00, instr_counter} :
      (ra == REG_STAT)   ? status :
      (ra == REG_SUM)    ? sum_latch :
      (ra == REG_NEXTOP) ? {16'h0000, next_op} :
      (ra == REG_QHI)    ? prefetch[63:32] :
      (ra == REG_QLO)    ? prefetch[31:0] :
      (ra == REG_GADDR)  ? {28'h000_0000, gpr_addr} :
      (ra == REG_GDATA)  ? local_store[gpr_addr] :
                           32'h0000_0000;

   assign s_axi_awready = !aw_full;
   assign s_axi_wready  = !w_full;
   assign s_axi_arready = !s_axi_rvalid;
   assign storage_req   = (state == S_REQ);
   assign storage_addr  = instr_counter;
   assign end_op        = done && (state == S_IDLE) && !w_ctrl &&
                          end_pulse;

   // ****************************************
   // Sequencer next state
   // ****************************************
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE:   if (start) next_state = S_MOVE;
         S_MOVE:   next_state = S_ADD;
         S_ADD:    next_state = S_CMP;
         S_CMP:    next_state = S_DECIDE;
         S_DECIDE: begin
            if (take && d_hw == HW_LAST) begin
               next_state = S_REQ;
            end else if (take) begin
               next_state = S_IDLE;
            end else if (seq_need) begin
               next_state = S_REQ;
            end else begin
               next_state = S_IDLE;
            end
         end
         S_REQ:    begin
            if (fill_mode != FM_TARGET && exec_flag) begin
               next_state = S_IDLE;
            end else begin
               next_state = S_WAIT;
            end
         end
         S_WAIT:   if (wait_cnt == 2'h0) next_state = S_FILL;
         S_FILL:   next_state = S_IDLE;
         default:  next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // Operand path
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sum_latch            <= 32'h0000_0000;
         work                 <= 32'h0000_0000;
         adder_result_latches <= 1'b0;
         seq_need             <= 1'b0;
         success              <= 1'b0;
      end else begin
         case (state)
            S_MOVE: begin
               sum_latch <= first_op;
               work      <= local_store[r3];
            end
            S_ADD: begin
               sum_latch <= add_sum;
               work      <= local_store[cmp_reg];
            end
            S_CMP: begin
               adder_result_latches <= add_pos;
               seq_need             <= hw_edge;
            end
            S_DECIDE: begin
               work    <= sum_latch;
               success <= take;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (gpr_wb) begin
         local_store[r1] <= sum_latch;
      end else if (w_gdata) begin
         local_store[gpr_addr] <= (local_store[gpr_addr] & ~wmask) |
                                  (w_data & wmask);
      end
   end

   // ****************************************
   // Counter, prefetch buffer, next-op latch
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         instr_counter <= 24'h00_0000;
         prefetch      <= 64'h0000_0000_0000_0000;
         next_op       <= 16'h0000;
         fill_mode     <= FM_TARGET;
         wait_cnt      <= 2'h0;
         end_branch    <= 1'b0;
      end else begin
         if (wr_idle && wa == REG_ICNT) begin
            instr_counter <= (instr_counter & ~wmask[23:0]) |
                             (w_data[23:0] & wmask[23:0]);
         end
         case (state)
            S_DECIDE: begin
               if (take) begin
                  prefetch      <= storage_out_bus;
                  next_op       <= d_half;
                  instr_counter <= baddr + DW_STEP;
                  fill_mode     <= FM_TARGET;
                  end_branch    <= (d_hw != HW_LAST);
               end else begin
                  fill_mode  <= (cnt_hw == HW_LAST) ? FM_SEQ_LAST
                                                   : FM_SEQ_FIRST;
                  end_branch <= 1'b0;
               end
            end
            S_REQ: begin
               wait_cnt <= STORE_LAT - 2'h1;
               if (!(fill_mode != FM_TARGET && exec_flag)) begin
                  instr_counter <= instr_counter + DW_STEP;
               end
            end
            S_WAIT: begin
               wait_cnt <= wait_cnt - 2'h1;
            end
            S_FILL: begin
               prefetch   <= storage_out_bus;
               end_branch <= (fill_mode != FM_TARGET);
               if (fill_mode == FM_SEQ_FIRST) begin
                  next_op <= q_first;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Flags and completion
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prefetch_invalid_flag <= 1'b0;
         exec_flag             <= 1'b0;
         done                  <= 1'b0;
         end_pulse             <= 1'b0;
      end else begin
         // Software set wins over the sequencer clear
         prefetch_invalid_flag <= set_pfi |
                                  (prefetch_invalid_flag & !clr_flag);
         exec_flag             <= set_exec | (exec_flag & !clr_flag);
         end_pulse             <= !idle && (next_state == S_IDLE);
         if (start) begin
            done <= 1'b0;
         end else if (!idle && next_state == S_IDLE) begin
            done <= 1'b1;
         end
      end
   end

   // ****************************************
   // Software loaded operands
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         instr    <= 16'h0000;
         first_op <= 32'h0000_0000;
         baddr    <= 24'h00_0000;
         gpr_addr <= 4'h0;
      end else if (wr_idle) begin
         // Writes while busy are dropped to protect operands
         if (wa == REG_INSTR) begin
            instr <= (instr & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
         end else if (wa == REG_FIRST) begin
            first_op <= (first_op & ~wmask) | (w_data & wmask);
         end else if (wa == REG_BADDR) begin
            baddr <= (baddr & ~wmask[23:0]) | (w_data[23:0] & wmask[23:0]);
         end else if (wa == REG_GADDR && w_strb[0]) begin
            gpr_addr <= w_data[3:0];
         end
      end
   end

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
         w_full  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_full <= 1'b0;
         end
         if (s_axi_wvalid && !w_full) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= AXI_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
            s_axi_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : branch_index_high_seq

// ### sim/branch_index_high_seq_checker.sv
`timescale 1ns/1ps
// ****
// Sequencer and register bus checks
// ****
module branch_index_high_seq_checker
   import branch_seq_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              storage_req,
   input wire logic              end_op,
   input wire logic              end_branch
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   chk_end_pulse: assert property (end_op |=> !end_op)
      else $error("end_op held longer than one cycle");
   chk_req_spacing: assert property (storage_req |=> !storage_req [*5])
      else $error("second storage request in one sequence");
   chk_req_to_end: assert property (storage_req |-> ##[1:6] end_op)
      else $error("no end-op after storage request");
   chk_end_no_req: assert property (end_op |-> !storage_req)
      else $error("storage request during end-op");
   // Execute subject ends right after its request
   chk_exec_normal: assert property (
      (storage_req ##[1:2] end_op) |-> !end_branch)
      else $error("quick end after request was a branch end-op");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   chk_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr > ADDR_W'(REG_GDATA) |=> s_axi_rvalid &&
      s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");

   cov_req: cover property (storage_req);
   cov_branch_end: cover property (end_op && end_branch);
   cov_normal_end: cover property (end_op && !end_branch);
   cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule : branch_index_high_seq_checker

bind branch_index_high_seq branch_index_high_seq_checker #(
   .ADDR_W(ADDR_W)) chk_u (
   .ref_clk(ref_clk), .rst(rst), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .storage_req(storage_req), .end_op(end_op), .end_branch(end_branch));

// ### sim/main_store_model.sv
`timescale 1ns/1ps
// ****
// Main storage, fixed latency
// ****
module main_store_model (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        storage_req,
   input  wire logic [23:0] storage_addr,
   input  wire logic        fetch_req,
   input  wire logic [23:0] fetch_addr,
   output      logic [63:0] storage_out_bus
);
   logic [23:0] cur;
   logic [1:0]  wait_cnt;

   function automatic logic [63:0] dw(input logic [23:0] a);
      return {a[18:3], ~a[18:3], a[18:3] ^ 16'h5555, a[18:3] ^ 16'hAAAA};
   endfunction : dw

   // three-cycle answer
   // Inverted data while waiting, so an early sample shows up
   assign storage_out_bus = (wait_cnt == 2'h0) ? dw(cur) : ~dw(cur);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur <= 24'h00_0000;
         wait_cnt <= 2'h0;
      end else if (storage_req || fetch_req) begin
         cur <= fetch_req ? fetch_addr : storage_addr;
         wait_cnt <= 2'h2;
      end else if (wait_cnt != 2'h0) begin
         wait_cnt <= wait_cnt - 2'h1;
      end
   end
endmodule : main_store_model

// ### sim/branch_index_high_seq_tb.sv
`timescale 1ns/1ps
module branch_index_high_seq_tb;
   import branch_seq_pkg::*;
   logic        ref_clk, rst, awv, wv, bre, arv, rre, freq, ex, ps;
   logic        awr, wrd, bv, arr, rv, sreq, eop, ebr;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdd;
   logic [1:0]  brs, rrs;
   logic [23:0] sad, fad;
   logic [63:0] sbus, exq;
   logic [15:0] nop;
   logic [3:0]  ws;
   logic [65:0] note;
   logic [23:0] q_req[$];
   logic        q_end[$];
   logic [65:0] q_rd[$];
   logic [1:0]  q_b[$];
   int          errors, tests_run, seed, i;
   logic [6:0]  cases [10] = '{7'h76, 7'h50, 7'h2C, 7'h30, 7'h02,
                               7'h0C, 7'h48, 7'h18, 7'h35, 7'h64};

   branch_index_high_seq dut_u (
      .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdd), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .storage_req(sreq), .storage_addr(sad),
      .storage_out_bus(sbus), .end_op(eop), .end_branch(ebr));
   main_store_model store_u (
      .ref_clk(ref_clk), .rst(rst), .storage_req(sreq),
      .storage_addr(sad), .fetch_req(freq), .fetch_addr(fad),
      .storage_out_bus(sbus));

   function automatic logic [63:0] dw(input logic [23:0] a);
      return {a[18:3], ~a[18:3], a[18:3] ^ 16'h5555, a[18:3] ^ 16'hAAAA};
   endfunction : dw

   task automatic cmp(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = AXI_OKAY,
                     input logic [3:0] s = 4'hF);
      logic ta, tw, tb;
      q_b.push_back(r);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge ref_clk);
         ta = awv & awr;
         tw = wv & wrd;
         tb = bv;
         @(posedge ref_clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      bre <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF,
                     input logic [1:0] r = AXI_OKAY);
      logic ta, tr;
      q_rd.push_back({r, m, e & m});
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge ref_clk);
         ta = arv & arr;
         tr = rv;
         @(posedge ref_clk);
         if (ta) arv <= 1'b0;
      end
      rre <= 1'b0;
      @(posedge ref_clk);
   endtask : rd

   // c: success, target halfword, counter halfword, execute, odd R3
   task automatic run_case(input logic [6:0] c);
      logic [31:0] fst, inc, cv, sum;
      logic [23:0] ba, cnt, cnt_exp;
      logic [63:0] t;
      logic [3:0]  r1, r3;
      logic        s, eb, p;
      int          k;
      fst = $random(seed) >>> 2;
      inc = $random(seed) >>> 2;
      sum = fst + inc;
      cv = c[6] ? sum - 32'h0000_0001 - (sum & 32'h0000_0007)
                : sum + (inc & 32'h0000_0007);
      if (c[0]) cv = inc;
      s = $signed(sum) > $signed(cv);
      r3 = 4'($random(seed));
      r3[0] = c[0];
      r1 = 4'($random(seed));
      p = 1'($random(seed));
      ba = {5'h00, 16'($random(seed)), c[5:4], 1'b0};
      cnt = {5'h00, 16'($random(seed)), c[3:2], 1'b0};
      freq <= 1'b1;
      fad <= ba;
      @(posedge ref_clk);
      freq <= 1'b0;
      wr(REG_GADDR, 32'(r3));
      wr(REG_GDATA, inc);
      wr(REG_GADDR, 32'(r3 | 4'h1));
      wr(REG_GDATA, cv);
      wr(REG_INSTR, {16'h0000, OPC_BIX, r1, r3});
      wr(REG_FIRST, fst);
      wr(REG_BADDR, 32'(ba));
      wr(REG_ICNT, 32'(cnt));
      wr(REG_CTRL, {29'h0000_0000, p, c[1], 1'b0});
      ex = ex | c[1];
      ps = ps | p;
      eb = 1'b0;
      cnt_exp = cnt;
      if (s) begin
         ex = 1'b0;
         ps = 1'b0;
         t = dw(ba);
         nop = t[63 - 16 * int'(c[5:4]) -: 16];
         eb = (c[5:4] != HW_LAST);
         cnt_exp = ba + DW_STEP;
         exq = t;
         if (!eb) begin
            q_req.push_back(ba + DW_STEP);
            cnt_exp = ba + DW_STEP + DW_STEP;
            exq = dw(ba + DW_STEP);
         end
      end else if (c[3:2] == HW_LAST || c[3:2] == HW_FIRST) begin
         q_req.push_back(cnt);
         if (!ex) begin
            t = dw(cnt);
            eb = 1'b1;
            cnt_exp = cnt + DW_STEP;
            exq = t;
            if (c[3:2] == HW_FIRST) nop = t[63:48];
         end
      end
      q_end.push_back(eb);
      wr(REG_CTRL, 32'h0000_0001);
      for (k = 0; k < 40 && q_end.size() != 0; k++) @(posedge ref_clk);
      cmp("pending", 32'h0000_0000,
          32'(q_req.size() + q_end.size()));
      rd(REG_SUM, sum);
      rd(REG_ICNT, 32'(cnt_exp));
      rd(REG_NEXTOP, 32'(nop));
      rd(REG_QHI, exq[63:32]);
      rd(REG_QLO, exq[31:0]);
      rd(REG_STAT, {26'h000_0000, eb, s, ex, ps, 2'h0}, 32'h0000_003D);
      wr(REG_GADDR, 32'(r1));
      rd(REG_GDATA, sum);
      $display("case %h done", c);
   endtask : run_case

   always @(posedge ref_clk) begin
      if (sreq === 1'b1) cmp("addr", 32'(q_req.pop_front()), 32'(sad));
      if (eop === 1'b1) cmp("end", 32'(q_end.pop_front()), 32'(ebr));
      if (bv === 1'b1 && bre === 1'b1)
         cmp("bresp", 32'(q_b.pop_front()), 32'(brs));
      if (rv === 1'b1 && rre === 1'b1) begin
         note = q_rd.pop_front();
         cmp("rdata", note[31:0], rdd & note[63:32]);
         cmp("rresp", 32'(note[65:64]), 32'(rrs));
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Whole run is about eight hundred cycles
   initial begin
      repeat (8000) @(posedge ref_clk);
      errors++;
      give_verdict();
   end

   initial begin
      seed = 32;
      errors = 0;
      tests_run = 0;
      rst = 1'b1;
      {awv, wv, bre, arv, rre, freq, ex, ps} = 8'h00;
      {awa, ara, wd, fad, nop, exq, ws} = '0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(REG_STAT, 32'h0000_0000);
      rd(REG_ICNT, 32'h0000_0000);
      wr(REG_ICNT, 32'h00AB_CDEF);
      wr(REG_ICNT, 32'h0011_2233, AXI_OKAY, 4'h2);
      rd(REG_ICNT, 32'h00AB_22EF);
      rd(8'h30, 32'h0000_0000, 32'hFFFF_FFFF, AXI_SLVERR);
      wr(8'h06, 32'h0000_0001, AXI_SLVERR);
      $display("reset test done");
      for (i = 0; i < 10; i++) run_case(cases[i]);
      wr(REG_INSTR, 32'h0000_8700);
      wr(REG_CTRL, 32'h0000_0001);
      rd(REG_STAT, 32'h0000_0040, 32'h0000_0041);
      repeat (20) @(posedge ref_clk);
      rd(REG_STAT, 32'h0000_0040, 32'h0000_0041);
      $display("opcode test done");
      give_verdict();
   end
endmodule : branch_index_high_seq_tb
